// ==== twc_pkg.sv ====
/*
 * Constants, types and register map of the telltale warning controller.
 * Assumes a single 125 MHz clock shared by every file that imports it.
 */
package twc_pkg;
    // =====================================================
    // Timing
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int PRECHECK_MS = 3000;
    localparam int BELT_FLASH_MS = 6000;
    localparam int BELT_STEADY_MS = 24000;
    localparam int FLASH_HALF_MS = 500;
    localparam int TW = 9;
    localparam logic [TW-1:0] PRECHECK_TK = TW'(PRECHECK_MS / TICK_MS);
    localparam logic [TW-1:0] BELT_FLASH_TK = TW'(BELT_FLASH_MS / TICK_MS);
    localparam logic [TW-1:0] BELT_STEADY_TK = TW'(BELT_STEADY_MS / TICK_MS);
    localparam logic [TW-1:0] FLASH_HALF_TK = TW'(FLASH_HALF_MS / TICK_MS);
    // =====================================================
    // Speed thresholds in km/h
    localparam logic [7:0] SPD_HI_KMH = 8'h10;
    localparam logic [7:0] SPD_LO_KMH = 8'h05;
    // =====================================================
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_LAMPS = 8'h0C;
    localparam logic [7:0] REG_STATE = 8'h10;
    localparam int NEV = 5;
    localparam logic CTRL_RST = 1'h0;
    localparam logic [NEV-1:0] MASK_RST = 5'h00;
    // =====================================================
    // Types
    typedef struct packed {
        logic ignition;
        logic key_in;
        logic belt_fastened;
        logic [3:0] door_open;
        logic park_lamp;
        logic fog_front;
        logic fog_rear;
        logic two_wheel_high_range;
        logic four_wheel_high_range;
        logic four_wheel_low_range;
        logic engine_management_unit_ok;
        logic restraint_system_fault;
        logic immobilized;
        logic auth_ok;
        logic key_fault;
        logic [7:0] speed_kmh;
    } twc_in_s;
    typedef struct packed {
        logic restraint_system;
        logic seat_belt;
        logic immobilizer;
        logic fog_front;
        logic fog_rear;
        logic door_open;
        logic four_wheel_high_range;
        logic four_wheel_low_range;
        logic check_engine;
    } twc_lamp_s;
    typedef enum logic [2:0] {
        SB_OFF, SB_PRE, SB_IDLE, SB_LOW_FLASH, SB_LOW_STEADY, SB_HI_FLASH,
        SB_HI_STEADY
    } twc_belt_e;
endpackage : twc_pkg

// ==== twc_sync.sv ====
/*
 * Two-stage synchroniser for a bundle of pin inputs.
 * Assumes each bit changes slowly compared with the clock.
 */
`timescale 1ns/1ps
module twc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    // =====================================================
    // Stages
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : twc_sync

// ==== twc_timer.sv ====
/*
 * Down-counter of timebase ticks, loaded with a tick count.
 * Assumes tick is a one-cycle enable pulse.
 */
`timescale 1ns/1ps
module twc_timer #(
    parameter int W = 9
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic load,
    input wire logic [W-1:0] val,
    output logic run
);
    logic [W-1:0] cnt;
    assign run = (cnt != '0);
    // =====================================================
    // Count
    always_ff @(posedge clk)
    begin
        if (rst)
            cnt <= '0;
        else if (load)
            cnt <= val;
        else if (tick && run)
            cnt <= cnt - W'(1);
    end
endmodule : twc_timer

// ==== twc_top.sv ====
/*
 * Telltale lamp and buzzer sequencing for an instrument cluster.
 * Assumes switch and controller inputs are asynchronous pins and that
 * software uses the plain register port on the same clock.
 */
`timescale 1ns/1ps
module twc_top
    import twc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input twc_pkg::twc_in_s pins,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    output twc_pkg::twc_lamp_s lamps,
    output logic buzzer,
    output logic irq
);
    import twc_pkg::*;

    twc_in_s in_s;
    logic ign_d;
    logic ign_rise;
    logic [31:0] tick_cnt;
    logic tick;
    logic [TW-1:0] half_cnt;
    logic flash_ph;
    logic chk_run;
    logic belt_run;
    logic belt_load;
    logic [TW-1:0] belt_val;
    twc_belt_e st;
    twc_belt_e next_st;
    twc_lamp_s next_lamps;
    logic next_buzzer;
    logic belt_buzz;
    logic door_buzz;
    logic ctrl_flash;
    logic [NEV-1:0] status;
    logic [NEV-1:0] mask;
    logic [NEV-1:0] cond;
    logic [NEV-1:0] cond_d;
    logic [NEV-1:0] ev;
    logic fast;
    logic slow;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    // =====================================================
    // Input synchronisers
    twc_sync #(.W($bits(twc_in_s))) u_sync (
        .clk(clk),
        .rst(rst),
        .d(pins),
        .q(in_s)
    );

    // =====================================================
    // Ignition edge
    always_ff @(posedge clk)
    begin
        if (rst)
            ign_d <= 1'b0;
        else
            ign_d <= in_s.ignition;
    end
    assign ign_rise = in_s.ignition && !ign_d;

    // =====================================================
    // Timebase, restarted at ignition so checks last full length
    always_ff @(posedge clk)
    begin
        if (rst || ign_rise || tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 32'h1;
    end
    assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    // =====================================================
    // Common flash phase
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            half_cnt <= '0;
            flash_ph <= 1'b0;
        end
        else if (tick)
        begin
            if (half_cnt == FLASH_HALF_TK - TW'(1))
            begin
                half_cnt <= '0;
                flash_ph <= !flash_ph;
            end
            else
                half_cnt <= half_cnt + TW'(1);
        end
    end

    // =====================================================
    // Ignition-on check interval
    twc_timer #(.W(TW)) u_chk (
        .clk(clk),
        .rst(rst),
        .tick(tick),
        .load(ign_rise),
        .val(PRECHECK_TK),
        .run(chk_run)
    );

    // =====================================================
    // Seat-belt sequence timer
    twc_timer #(.W(TW)) u_belt (
        .clk(clk),
        .rst(rst),
        .tick(tick),
        .load(belt_load),
        .val(belt_val),
        .run(belt_run)
    );

    assign fast = (in_s.speed_kmh > SPD_HI_KMH);
    assign slow = (in_s.speed_kmh <= SPD_LO_KMH);

    // =====================================================
    // Seat-belt state machine
    always_comb
    begin
        next_st = st;
        belt_load = 1'b0;
        belt_val = BELT_FLASH_TK;
        if (!in_s.ignition)
            next_st = SB_OFF;
        else if (ign_rise)
            next_st = SB_PRE;
        else
        begin
            unique case (st)
                SB_OFF: next_st = SB_OFF;
                SB_PRE:
                    if (!chk_run)
                    begin
                        if (in_s.belt_fastened)
                            next_st = SB_IDLE;
                        else
                        begin
                            next_st = SB_LOW_FLASH;
                            belt_load = 1'b1;
                        end
                    end
                SB_IDLE:
                    if (!in_s.belt_fastened)
                        next_st = SB_LOW_STEADY;
                SB_LOW_FLASH:
                    if (in_s.belt_fastened)
                        next_st = SB_IDLE;
                    else if (!belt_run)
                        next_st = SB_LOW_STEADY;
                SB_LOW_STEADY:
                    if (in_s.belt_fastened)
                        next_st = SB_IDLE;
                    else if (fast)
                    begin
                        next_st = SB_HI_FLASH;
                        belt_load = 1'b1;
                    end
                SB_HI_FLASH, SB_HI_STEADY:
                    if (in_s.belt_fastened)
                        next_st = SB_IDLE;
                    else if (slow)
                        next_st = SB_LOW_STEADY;
                    else if (!belt_run)
                    begin
                        belt_load = 1'b1;
                        if (st == SB_HI_FLASH)
                        begin
                            next_st = SB_HI_STEADY;
                            belt_val = BELT_STEADY_TK;
                        end
                        else
                            next_st = SB_HI_FLASH;
                    end
                default: next_st = SB_OFF;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st <= SB_OFF;
        else
            st <= next_st;
    end

    // =====================================================
    // Lamp and buzzer decisions
    assign belt_buzz = (st == SB_LOW_FLASH) || (st == SB_HI_FLASH);
    assign door_buzz = in_s.key_in && (|in_s.door_open);

    always_comb
    begin
        next_lamps = '0;
        unique case (st)
            SB_PRE, SB_LOW_STEADY, SB_HI_STEADY: next_lamps.seat_belt = 1'b1;
            SB_LOW_FLASH, SB_HI_FLASH: next_lamps.seat_belt = flash_ph;
            default: next_lamps.seat_belt = 1'b0;
        endcase
        if (chk_run)
            next_lamps.restraint_system = 1'b1;
        else if (in_s.restraint_system_fault)
            next_lamps.restraint_system = ctrl_flash ? flash_ph : 1'b1;
        next_lamps.check_engine = chk_run || !in_s.engine_management_unit_ok;
        if (in_s.key_fault)
            next_lamps.immobilizer = 1'b1;
        else if (in_s.immobilized && !in_s.key_in && !in_s.auth_ok)
            next_lamps.immobilizer = flash_ph;
        next_lamps.fog_front = in_s.fog_front;
        next_lamps.fog_rear = in_s.fog_rear;
        next_lamps.door_open = |in_s.door_open;
        if (chk_run && in_s.two_wheel_high_range)
        begin
            next_lamps.four_wheel_high_range = 1'b1;
            next_lamps.four_wheel_low_range = 1'b1;
        end
        else
        begin
            next_lamps.four_wheel_high_range = in_s.four_wheel_high_range;
            next_lamps.four_wheel_low_range = in_s.four_wheel_low_range;
        end
        next_buzzer = belt_buzz || door_buzz
            || (!in_s.key_in && in_s.park_lamp && in_s.door_open[0]);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lamps <= '0;
            buzzer <= 1'b0;
        end
        else
        begin
            lamps <= next_lamps;
            buzzer <= next_buzzer;
        end
    end

    // =====================================================
    // Events: rising edges of warning conditions
    assign cond = {in_s.key_fault, door_buzz, belt_buzz,
        !chk_run && in_s.ignition && !in_s.engine_management_unit_ok,
        !chk_run && in_s.ignition && in_s.restraint_system_fault};
    always_ff @(posedge clk)
    begin
        if (rst)
            cond_d <= '0;
        else
            cond_d <= cond;
    end
    assign ev = cond & ~cond_d;

    // =====================================================
    // Status, mask and control registers
    always_ff @(posedge clk)
    begin
        if (rst)
            status <= '0;
        else if (bus_rd && hit(bus_addr, REG_STATUS))
            status <= ev;
        else
            status <= status | ev;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mask <= MASK_RST;
            ctrl_flash <= CTRL_RST;
        end
        else if (bus_wr)
        begin
            if (hit(bus_addr, REG_MASK))
                mask <= bus_wdata[NEV-1:0];
            if (hit(bus_addr, REG_CTRL))
                ctrl_flash <= bus_wdata[0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |((status | ev) & mask);
    end

    // =====================================================
    // Read port
    always_ff @(posedge clk)
    begin
        if (rst)
            bus_rdata <= '0;
        else if (bus_rd)
        begin
            bus_rdata <= '0;
            if (hit(bus_addr, REG_CTRL))
                bus_rdata <= {31'h0, ctrl_flash};
            else if (hit(bus_addr, REG_STATUS))
                bus_rdata <= {27'h0, status};
            else if (hit(bus_addr, REG_MASK))
                bus_rdata <= {27'h0, mask};
            else if (hit(bus_addr, REG_LAMPS))
                bus_rdata <= {22'h0, buzzer, lamps};
            else if (hit(bus_addr, REG_STATE))
                bus_rdata <= {16'h0, in_s.speed_kmh, 5'h0, st};
        end
    end

    // =====================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_pre_lamp;
        st == SB_PRE |=> lamps.seat_belt;
    endproperty
    a_pre_lamp: assert property (p_pre_lamp) else $error("belt lamp off in pre-check");

    property p_low_flash;
        st == SB_LOW_FLASH |=> buzzer && (lamps.seat_belt == $past(flash_ph));
    endproperty
    a_low_flash: assert property (p_low_flash) else $error("low flash wrong");

    property p_steady;
        st == SB_LOW_STEADY && !door_buzz && in_s.key_in |=> lamps.seat_belt && !buzzer;
    endproperty
    a_steady: assert property (p_steady) else $error("steady phase wrong");

    sequence s_hi_go;
        st == SB_LOW_STEADY && in_s.ignition && !in_s.belt_fastened && fast && !ign_rise;
    endsequence
    property p_hi_go;
        s_hi_go |=> st == SB_HI_FLASH ##1 buzzer;
    endproperty
    a_hi_go: assert property (p_hi_go) else $error("high cycle not started");

    property p_hi_end;
        (st == SB_HI_FLASH || st == SB_HI_STEADY) && in_s.ignition && !ign_rise
            && !in_s.belt_fastened && slow |=> st == SB_LOW_STEADY;
    endproperty
    a_hi_end: assert property (p_hi_end) else $error("high cycle not ended");

    property p_fog;
        1'b1 |=> lamps.fog_front == $past(in_s.fog_front)
            && lamps.fog_rear == $past(in_s.fog_rear);
    endproperty
    a_fog: assert property (p_fog) else $error("fog indicator mismatch");

    property p_door_buzz;
        door_buzz |=> buzzer && lamps.door_open;
    endproperty
    a_door_buzz: assert property (p_door_buzz) else $error("door buzzer silent");

    property p_chk;
        chk_run |=> lamps.restraint_system && lamps.check_engine;
    endproperty
    a_chk: assert property (p_chk) else $error("check lamps off");

    property p_eng;
        !rst && !chk_run |=> lamps.check_engine == !$past(in_s.engine_management_unit_ok);
    endproperty
    a_eng: assert property (p_eng) else $error("check-engine lamp wrong");

    property p_rng;
        !chk_run |=> lamps.four_wheel_low_range == $past(in_s.four_wheel_low_range);
    endproperty
    a_rng: assert property (p_rng) else $error("range lamp wrong");

endmodule : twc_top

// ==== twc_vehicle.sv ====
/*
 * Vehicle-side model: switches, sensors and controller status lines.
 * Assumes the bench sets the wanted pin levels just after a clock edge.
 */
`timescale 1ns/1ps
module twc_vehicle
    import twc_pkg::*;
(
    input wire logic clk,
    input twc_pkg::twc_in_s want,
    output twc_pkg::twc_in_s pins
);
    twc_in_s lvl;
    // =====================================================
    // Pin levels
    always @(posedge clk)
    begin
        lvl = want;
        // Transfer case in low range cannot also sit in a high range
        if (want.four_wheel_low_range)
        begin
            lvl.two_wheel_high_range = 1'b0;
            lvl.four_wheel_high_range = 1'b0;
        end
        pins <= lvl;
    end
endmodule : twc_vehicle

// ==== twc_top_test.sv ====
/*
 * Self-checking bench for the telltale controller, register reads as results.
 * Assumes the vehicle model and a tick of four clock cycles.
 */
`timescale 1ns/1ps
module twc_top_test;
    import twc_pkg::*;
    typedef struct {string name; logic [31:0] exp; logic [31:0] msk;} twc_note_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    twc_in_s want = '0;
    twc_in_s pins;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic rd_q = 1'b0;
    logic [31:0] bus_rdata;
    twc_lamp_s lamps;
    logic buzzer;
    logic irq;
    int fail_count = 0;
    int tests_run = 0;
    twc_note_s notes[$];
    twc_note_s n;
    logic [3:0] dr;
    logic kin, pk, ff, fr;
    int c;
    logic [31:0] e;
    // =====================================================
    // Instances
    twc_vehicle i_twc_vehicle (.clk(clk), .want(want), .pins(pins));
    twc_top #(.TICK_CYCLES(4)) i_twc_top (.clk(clk), .rst(rst), .pins(pins),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .lamps(lamps), .buzzer(buzzer), .irq(irq));
    initial
    begin
        forever #4 clk = ~clk;
    end
    // =====================================================
    // Tasks
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : wr
    task rd(input string name, input logic [7:0] a, input logic [31:0] e,
            input logic [31:0] m);
        @(posedge clk);
        notes.push_back('{name, e, m});
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
    endtask : rd
    task count_on(input bit restraint);
        c = 0;
        repeat (80)
        begin
            @(posedge clk);
            c += restraint ? int'(lamps.restraint_system) : int'(lamps.immobilizer);
        end
    endtask : count_on
    task end_test(input string name);
        $display("test %s done", name);
    endtask : end_test
    // =====================================================
    // Result watcher
    always @(posedge clk)
    begin
        if (rd_q)
        begin
            if (notes.size() == 0)
                check("note queue", 32'h1, 32'h0);
            else
            begin
                n = notes.pop_front();
                check(n.name, bus_rdata & n.msk, n.exp & n.msk);
            end
        end
        rd_q <= bus_rd;
    end
    initial
    begin
        cyc(20000);
        check("timeout", 32'h1, 32'h0);
        give_verdict();
    end
    // =====================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'hea76));
        cyc(3);
        rst <= 1'b0;
        rd("ctrl", REG_CTRL, 32'h0, '1);
        rd("mask", REG_MASK, 32'h0, '1);
        rd("lamps", REG_LAMPS, 32'h001, '1);
        wr(8'h20, 32'hFFFF_FFFF);
        rd("unmapped", 8'h20, 32'h0, '1);
        wr(REG_CTRL, 32'h1);
        rd("ctrl", REG_CTRL, 32'h1, '1);
        wr(REG_CTRL, 32'h0);
        end_test("registers");
        want.engine_management_unit_ok <= 1'b1;
        want.two_wheel_high_range <= 1'b1;
        want.ignition <= 1'b1;
        want.key_in <= 1'b1;
        cyc(60);
        rd("lamps", REG_LAMPS, 32'h187, '1);
        rd("state", REG_STATE, 32'h1, '1);
        cyc(176);
        rd("lamps", REG_LAMPS, 32'h200, 32'h37F);
        rd("state", REG_STATE, 32'h3, '1);
        rd("status", REG_STATUS, 32'h4, '1);
        rd("status", REG_STATUS, 32'h0, '1);
        cyc(176);
        rd("lamps", REG_LAMPS, 32'h080, '1);
        rd("state", REG_STATE, 32'h4, '1);
        want.speed_kmh <= 8'h10;
        cyc(8);
        rd("state", REG_STATE, 32'h1004, '1);
        want.speed_kmh <= 8'h14;
        cyc(100);
        rd("lamps", REG_LAMPS, 32'h200, 32'h37F);
        rd("state", REG_STATE, 32'h1405, '1);
        cyc(236);
        rd("lamps", REG_LAMPS, 32'h080, '1);
        rd("state", REG_STATE, 32'h1406, '1);
        cyc(956);
        rd("state", REG_STATE, 32'h1405, '1);
        want.speed_kmh <= 8'h05;
        cyc(8);
        rd("state", REG_STATE, 32'h0504, '1);
        want.speed_kmh <= 8'h11;
        cyc(8);
        rd("state", REG_STATE, 32'h1105, '1);
        want.belt_fastened <= 1'b1;
        cyc(8);
        rd("state", REG_STATE, 32'h1102, '1);
        rd("lamps", REG_LAMPS, 32'h0, '1);
        end_test("seat belt");
        for (int i = 0; i < 8; i++)
        begin
            dr = 4'($urandom());
            {kin, pk, ff, fr} = 4'($urandom());
            want.door_open <= dr;
            want.key_in <= kin;
            want.park_lamp <= pk;
            want.fog_front <= ff;
            want.fog_rear <= fr;
            cyc(6);
            e = {22'h0, (kin & |dr) | (!kin & pk & dr[0]), 3'b0, ff, fr, |dr, 3'b0};
            rd("lamps", REG_LAMPS, e, '1);
            check("lamp pins", {22'h0, buzzer, lamps}, e);
        end
        want.door_open <= 4'h0;
        want.key_in <= 1'b0;
        want.park_lamp <= 1'b0;
        want.fog_front <= 1'b0;
        want.fog_rear <= 1'b0;
        want.key_fault <= 1'b1;
        cyc(6);
        rd("lamps", REG_LAMPS, 32'h040, '1);
        want.key_fault <= 1'b0;
        want.immobilized <= 1'b1;
        cyc(6);
        count_on(1'b0);
        check("blink", 32'(c), 32'd40);
        want.immobilized <= 1'b0;
        want.auth_ok <= 1'b1;
        want.key_in <= 1'b1;
        want.two_wheel_high_range <= 1'b0;
        want.four_wheel_high_range <= 1'b1;
        cyc(6);
        rd("lamps", REG_LAMPS, 32'h004, '1);
        want.four_wheel_low_range <= 1'b1;
        cyc(6);
        rd("lamps", REG_LAMPS, 32'h002, '1);
        end_test("lamps");
        wr(REG_MASK, 32'h0);
        rd("status", REG_STATUS, 32'h14, 32'h17);
        want.ignition <= 1'b0;
        cyc(5);
        want.engine_management_unit_ok <= 1'b0;
        want.restraint_system_fault <= 1'b1;
        want.ignition <= 1'b1;
        cyc(200);
        rd("lamps", REG_LAMPS, 32'h103, '1);
        check("irq", {31'h0, irq}, 32'h0);
        wr(REG_MASK, 32'h3);
        rd("mask", REG_MASK, 32'h3, '1);
        check("irq", {31'h0, irq}, 32'h1);
        rd("status", REG_STATUS, 32'h3, '1);
        cyc(3);
        check("irq", {31'h0, irq}, 32'h0);
        wr(REG_CTRL, 32'h1);
        cyc(4);
        count_on(1'b1);
        check("flash", 32'(c), 32'd40);
        end_test("faults");
        cyc(4);
        give_verdict();
    end
endmodule : twc_top_test
